// ===== verification/tx_cell_packet_framing_input_test.sv
// Self-checking bench: source and device joined over the framing link
`timescale 1ns/1ps
module tx_cell_packet_framing_input_test import txfr_pkg::*; ;
    // Stimulus and channel setup
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        uv, uf, ul, ua, s_sense, d_sense, need;
    logic [2:0]  up;
    logic [63:0] ud, data;
    txfr_mode_t  mode;
    // Device outputs
    logic        wr, first, last, abt, perr, disc;
    logic [7:0]  lanes;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;

    txfr_link_if link (.tx_interface_clock(core_clk));
    txfr_source u_txfr_source (.core_clk(core_clk), .reset(reset),
        .link(link), .user_valid(uv), .user_data(ud), .user_first(uf),
        .user_last(ul), .user_pad(up), .user_abort(ua),
        .tx_parity_sense_select(s_sense), .need_start_q(need));
    txfr_device u_txfr_device (.core_clk(core_clk), .reset(reset),
        .link(link), .mode(mode), .tx_parity_sense_select(d_sense),
        .fifo_wr_q(wr), .fifo_data_q(data), .fifo_first_q(first),
        .fifo_last_q(last), .fifo_byte_valid_q(lanes),
        .fifo_abort_q(abt), .parity_error_q(perr), .discarding_q(disc));
    txfr_link_properties u_txfr_link_properties (.core_clk(core_clk),
        .reset(reset), .mode(mode), .tx_parity_sense_select(d_sense),
        .tx_write_enable(link.tx_write_enable),
        .tx_word_bus(link.tx_word_bus),
        .tx_frame_start_flag(link.tx_frame_start_flag),
        .tx_frame_end_flag(link.tx_frame_end_flag),
        .tx_word_parity(link.tx_word_parity),
        .tx_packet_abort_flag(link.tx_packet_abort_flag),
        .tx_pad_byte_count(link.tx_pad_byte_count),
        .fifo_wr_q(wr), .fifo_data_q(data), .fifo_first_q(first),
        .fifo_last_q(last), .fifo_byte_valid_q(lanes),
        .fifo_abort_q(abt), .parity_error_q(perr), .discarding_q(disc));

    always #5 core_clk = ~core_clk;

    // Run needs about 45 cycles, so 500 only trips on a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One word through source and link; device answers two edges later
    task automatic send(input logic f, l, a, input logic [2:0] p,
                        input logic [63:0] d, input logic [4:0] ef,
                        input logic [7:0] ev);
        {uv, uf, ul, ua, up, ud} = {1'b1, f, l, a, p, d};
        @(posedge core_clk);
        #1 uv = 1'b0;
        @(posedge core_clk);
        #1 chk("flags", ef, {wr, first, last, abt, disc});
        chk("lanes", ev, lanes & {8{wr}});
        chk("parity", s_sense ^ d_sense, perr);
        if (wr === 1'b1) chk("data", d, data);
    endtask : send

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial begin
        {uv, uf, ul, ua, s_sense, d_sense, up, ud} = '0;
        mode = TXFR_MODE_PACKET;
        repeat (5) @(posedge core_clk);
        #1 reset = 1'b0;
        // Packet: start, middle, then every pad code on the end word
        send(1, 0, 0, 0, 64'h0102030405060708, 5'b11000, 8'hff);
        send(0, 0, 0, 0, 64'h1112131415161718, 5'b10000, 8'hff);
        for (int p = 0; p < 8; p++) begin
            send(0, 1, 0, p[2:0], {8{p[7:0]}}, 5'b10100, 8'hff << p);
        end
        $display("packet test done");
        // Abort, dropped word, then recovery on a start word
        send(1, 0, 0, 0, 64'ha5, 5'b11000, 8'hff);
        send(0, 0, 1, 0, 64'hbad, 5'b00011, 8'h00);
        send(0, 0, 0, 0, 64'hdead, 5'b00001, 8'h00);
        send(1, 1, 0, 2, 64'hbeef, 5'b11100, 8'hfc);
        $display("abort test done");
        // Cell mode ignores end, pad and abort
        mode = TXFR_MODE_CELL;
        send(1, 1, 0, 5, 64'h77, 5'b11000, 8'hff);
        send(1, 0, 1, 0, 64'h66, 5'b10000, 8'hff);
        $display("cell test done");
        // Every pairing of source and device parity sense
        mode = TXFR_MODE_PACKET;
        for (int s = 0; s < 4; s++) begin
            {s_sense, d_sense} = s[1:0];
            send(1, 0, 0, 0, 64'h7 << s, 5'b11000, 8'hff);
        end
        $display("parity test done");
        give_verdict();
    end
endmodule : tx_cell_packet_framing_input_test

// ===== verification/txfr_link_properties.sv
// Concurrent checks on the framing link and the device word stream
`timescale 1ns/1ps
module txfr_link_properties import txfr_pkg::*; (
    // Clock, reset and channel setup
    input wire logic        core_clk,
    input wire logic        reset,
    input wire txfr_mode_t  mode,
    input wire logic        tx_parity_sense_select,
    // Link as driven by the source
    input wire logic        tx_write_enable,
    input wire logic [63:0] tx_word_bus,
    input wire logic        tx_frame_start_flag,
    input wire logic        tx_frame_end_flag,
    input wire logic        tx_word_parity,
    input wire logic        tx_packet_abort_flag,
    input wire logic [2:0]  tx_pad_byte_count,
    // Device word stream
    input wire logic        fifo_wr_q,
    input wire logic [63:0] fifo_data_q,
    input wire logic        fifo_first_q,
    input wire logic        fifo_last_q,
    input wire logic [7:0]  fifo_byte_valid_q,
    input wire logic        fifo_abort_q,
    input wire logic        parity_error_q,
    input wire logic        discarding_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Short aliases keep each property on a few lines
    wire logic pkt = (mode == TXFR_MODE_PACKET);
    wire logic we  = tx_write_enable;
    wire logic ab  = tx_packet_abort_flag;

    chk_start_word_first: assert property (
        we && tx_frame_start_flag && !(pkt && ab) |=> fifo_wr_q && fifo_first_q)
        else $error("start word not written as first");
    chk_data_kept: assert property (
        fifo_wr_q |-> fifo_data_q == $past(tx_word_bus))
        else $error("written word differs from link word");
    chk_cell_full_words: assert property (
        fifo_wr_q && $past(!pkt) |-> !fifo_last_q && fifo_byte_valid_q == 8'hff)
        else $error("cell word marked last or partial");
    chk_parity_flag: assert property (
        we |=> parity_error_q ==
        $past(^tx_word_bus ^ tx_word_parity ^ tx_parity_sense_select))
        else $error("parity error flag wrong");
    chk_abort_pulse: assert property (
        pkt && we && ab && !discarding_q |=>
        fifo_abort_q && !fifo_wr_q && discarding_q)
        else $error("abort word not turned into abort");
    chk_cell_no_abort: assert property (
        !pkt && we |=> !fifo_abort_q)
        else $error("abort honoured in cell mode");
    chk_discard_drops: assert property (
        discarding_q && we && !tx_frame_start_flag |=> !fifo_wr_q)
        else $error("word written while discarding");
    chk_pad_lanes: assert property (
        fifo_wr_q && fifo_last_q |->
        fifo_byte_valid_q == 8'hff << $past(tx_pad_byte_count))
        else $error("end word lanes wrong for pad count");
    chk_middle_full: assert property (
        fifo_wr_q && !fifo_last_q |-> fifo_byte_valid_q == 8'hff)
        else $error("non-end word not full");
    // Main scenarios reached
    cover property (fifo_abort_q);
    cover property (fifo_wr_q && fifo_last_q && fifo_byte_valid_q == 8'h80);
    cover property (parity_error_q);
endmodule : txfr_link_properties

// ===== verilog/txfr_device.sv
// Device end: samples link qualifiers, frames words, checks parity
`timescale 1ns/1ps
module txfr_device import txfr_pkg::*; #(
    parameter int WIDTH = 64
) (
    // Clock and reset (core_clk is the transmit interface clock)
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Link from the source
    txfr_link_if.device           link,
    // Channel configuration
    input  wire txfr_mode_t       mode,
    input  wire logic             tx_parity_sense_select,
    // Word stream toward the transmit FIFO
    output logic                  fifo_wr_q,
    output logic [WIDTH-1:0]      fifo_data_q,
    output logic                  fifo_first_q,
    output logic                  fifo_last_q,
    output logic [TXFR_MAX_BYTES-1:0] fifo_byte_valid_q,
    output logic                  fifo_abort_q,
    output logic                  parity_error_q,
    output logic                  discarding_q
);
    localparam int NBYTES = WIDTH / TXFR_BYTE_BITS;

    // Elaboration check: lane logic only serves these bus widths
    if (WIDTH != 8 && WIDTH != 16 && WIDTH != 32 && WIDTH != 64) begin : g_bad_width
        $error("txfr_device: WIDTH must be 8, 16, 32 or 64");
    end

    // Pad count masked to the bits the bus width uses
    function automatic logic [2:0] pad_mask(input logic [2:0] pad);
        case (NBYTES)
            8:       pad_mask = pad;                       // RULE_14
            4:       pad_mask = {1'b0, pad[1:0]};          // RULE_15
            2:       pad_mask = {2'b00, pad[0]};           // RULE_16
            default: pad_mask = 3'h0;                      // RULE_17
        endcase
    endfunction : pad_mask

    // Byte enables: first byte in top lane, padding in low lanes
    function automatic logic [TXFR_MAX_BYTES-1:0] lanes(input logic [2:0] p);
        logic [TXFR_MAX_BYTES-1:0] v;
        v = '0;
        for (int i = 0; i < TXFR_MAX_BYTES; i++)
            if (i < NBYTES && i >= int'(p))                // RULE_18 RULE_19
                v[i] = 1'b1;                               // RULE_20 RULE_02
        lanes = v;
    endfunction : lanes

    logic       is_pkt;
    logic       abort_now;
    logic       sof_now;
    logic       eof_now;
    logic       par_calc;
    logic       wr;

    // Qualifiers are logic on this same clock; used as sampled at edge
    assign is_pkt    = (mode == TXFR_MODE_PACKET);
    assign abort_now = is_pkt && link.tx_packet_abort_flag;     // RULE_06
    assign sof_now   = link.tx_frame_start_flag && !abort_now;  // RULE_10
    assign eof_now   = is_pkt && link.tx_frame_end_flag
                       && !abort_now;                           // RULE_03
    assign par_calc  = (^link.tx_word_bus) ^ tx_parity_sense_select; // RULE_21
    // Discard holds off writes until a start word, which is itself written
    assign wr = link.tx_write_enable && !abort_now
                && (!discarding_q || sof_now);                  // RULE_09

    // Discard state after an abort
    always_ff @(posedge core_clk) begin                         // RULE_05
        if (reset)
            discarding_q <= TXFR_RST_BIT;
        else if (link.tx_write_enable && abort_now)
            discarding_q <= 1'b1;                               // RULE_07
        else if (link.tx_write_enable && sof_now)
            discarding_q <= 1'b0;                               // RULE_08
    end

    // Word to FIFO with framing marks
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fifo_wr_q         <= TXFR_RST_BIT;
            fifo_data_q       <= '0;
            fifo_first_q      <= TXFR_RST_BIT;
            fifo_last_q       <= TXFR_RST_BIT;
            fifo_byte_valid_q <= '0;
        end else begin
            fifo_wr_q    <= wr;
            fifo_data_q  <= link.tx_word_bus;
            fifo_first_q <= wr && sof_now;                       // RULE_01
            fifo_last_q  <= wr && eof_now;
            // Partial words only on packet end words
            if (eof_now && is_pkt)                              // RULE_11 RULE_13
                fifo_byte_valid_q <= lanes(pad_mask(link.tx_pad_byte_count));
            else
                fifo_byte_valid_q <= lanes(3'h0);               // RULE_12
        end
    end

    // Abort pulse toward the line HDLC stage
    always_ff @(posedge core_clk) begin
        if (reset)
            fifo_abort_q <= TXFR_RST_BIT;
        else
            fifo_abort_q <= link.tx_write_enable && abort_now
                            && !discarding_q;                   // RULE_07
    end

    // Parity check on every written word
    always_ff @(posedge core_clk) begin
        if (reset)
            parity_error_q <= TXFR_RST_BIT;
        else
            parity_error_q <= link.tx_write_enable
                              && (par_calc != link.tx_word_parity); // RULE_04
    end
endmodule : txfr_device

// ===== verilog/txfr_link_if.sv
// Link between the data link layer source and the framing input device
`timescale 1ns/1ps
interface txfr_link_if #(parameter int WIDTH = 64) (
    input logic tx_interface_clock
);
    logic             tx_write_enable;
    logic [WIDTH-1:0] tx_word_bus;
    logic             tx_frame_start_flag;
    logic             tx_frame_end_flag;
    logic             tx_word_parity;
    logic             tx_packet_abort_flag;
    logic [2:0]       tx_pad_byte_count;

    modport source (
        output tx_write_enable, tx_word_bus, tx_frame_start_flag,
               tx_frame_end_flag, tx_word_parity, tx_packet_abort_flag,
               tx_pad_byte_count
    );
    modport device (
        input tx_write_enable, tx_word_bus, tx_frame_start_flag,
              tx_frame_end_flag, tx_word_parity, tx_packet_abort_flag,
              tx_pad_byte_count
    );
endinterface : txfr_link_if

// ===== verilog/txfr_pkg.sv
// Shared constants and types for the transmit framing input link
// Functional notes
// RULE_01 - Start flag marks every frame's first word
// RULE_02 - First byte sits in top byte lane
// RULE_03 - End flag marks packet last word; cell ignores
// RULE_04 - Parity bit per word, odd/even per channel
// RULE_05 - Qualifiers sampled on interface clock rising edge
// RULE_06 - Abort flag honoured only in packet mode
// RULE_07 - Abort flag aborts current packet on line
// RULE_08 - After abort, next word starts new packet
// RULE_09 - After abort, drop writes until start flag
// RULE_10 - Abort cycle ignores start and end flags
// RULE_11 - Pad count gives last word padding bytes
// RULE_12 - Only final word may be partially filled
// RULE_13 - Pad count read only on end words
// RULE_14 - 64-bit bus: zero to seven pad bytes
// RULE_15 - 32-bit bus: two low pad bits used
// RULE_16 - 16-bit bus: lowest pad bit only
// RULE_17 - 8-bit bus: pad count ignored entirely
// RULE_18 - 64-bit code 000: all eight bytes valid
// RULE_19 - Each higher code moves end lane up
// RULE_20 - 32/16-bit codes map to end lanes
// RULE_21 - Parity over full bus width, flag mismatch
package txfr_pkg;
    localparam int TXFR_MAX_WIDTH  = 64;
    localparam int TXFR_PAD_BITS   = 3;
    localparam int TXFR_BYTE_BITS  = 8;
    localparam int TXFR_MAX_BYTES  = TXFR_MAX_WIDTH / TXFR_BYTE_BITS;
    localparam logic TXFR_RST_BIT  = 1'b0;
    localparam logic [TXFR_PAD_BITS-1:0] TXFR_RST_PAD = 3'h0;
    // Parity sense: 0 selects even, 1 selects odd
    localparam logic TXFR_PAR_EVEN = 1'b0;
    localparam logic TXFR_PAR_ODD  = 1'b1;
    // Framing mode of the channel
    typedef enum logic {TXFR_MODE_CELL, TXFR_MODE_PACKET} txfr_mode_t;
endpackage : txfr_pkg

// ===== verilog/txfr_source.sv
// Source end: drives words with framing qualifiers onto the link
`timescale 1ns/1ps
module txfr_source import txfr_pkg::*; #(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Link toward the device
    txfr_link_if.source           link,
    // User side request
    input  wire logic             user_valid,
    input  wire logic [WIDTH-1:0] user_data,
    input  wire logic             user_first,
    input  wire logic             user_last,
    input  wire logic [2:0]       user_pad,
    input  wire logic             user_abort,
    input  wire logic             tx_parity_sense_select,
    // Status
    output logic                  need_start_q
);
    // Elaboration check: parity and data paths assume these widths
    if (WIDTH != 8 && WIDTH != 16 && WIDTH != 32 && WIDTH != 64) begin : g_bad_width
        $error("txfr_source: WIDTH must be 8, 16, 32 or 64");
    end

    logic             we_q;
    logic [WIDTH-1:0] data_q;
    logic             sof_q;
    logic             eof_q;
    logic             par_q;
    logic             err_q;
    logic [2:0]       pad_q;
    logic             go;

    assign link.tx_write_enable      = we_q;
    assign link.tx_word_bus          = data_q;
    assign link.tx_frame_start_flag  = sof_q;
    assign link.tx_frame_end_flag    = eof_q;
    assign link.tx_word_parity       = par_q;
    assign link.tx_packet_abort_flag = err_q;
    assign link.tx_pad_byte_count    = pad_q;

    // After an abort, words other than a start or another abort are held back
    assign go = user_valid && (user_abort || !need_start_q || user_first); // RULE_08

    // Track the need for a new start after an abort
    always_ff @(posedge core_clk) begin
        if (reset)
            need_start_q <= TXFR_RST_BIT;
        else if (user_valid && user_abort)
            need_start_q <= 1'b1;
        else if (go && user_first)
            need_start_q <= 1'b0;
    end

    // Register the link outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            we_q   <= TXFR_RST_BIT;
            data_q <= '0;
            sof_q  <= TXFR_RST_BIT;
            eof_q  <= TXFR_RST_BIT;
            par_q  <= TXFR_RST_BIT;
            err_q  <= TXFR_RST_BIT;
            pad_q  <= TXFR_RST_PAD;
        end else begin
            we_q   <= go;
            data_q <= user_data;                                 // RULE_02
            sof_q  <= go && user_first && !user_abort;           // RULE_01
            eof_q  <= go && user_last && !user_abort;            // RULE_03
            par_q  <= (^user_data) ^ tx_parity_sense_select;     // RULE_04
            err_q  <= go && user_abort;
            pad_q  <= (go && user_last) ? user_pad : TXFR_RST_PAD; // RULE_12
        end
    end
endmodule : txfr_source
